// File: inc/fvm_pkg.sv
// fvm_pkg: offsets, field positions and reset values of the vector monitor
// assumes a 12-bit word-granular register address and 32-bit data
package fvm_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_WORDS = 7;

    // observation words, read-only
    localparam logic [ADDR_W-1:0] OFS_STATIONARY_B_CURRENT = 12'h4d4;
    localparam logic [ADDR_W-1:0] OFS_STATIONARY_A_VOLTAGE = 12'h4d6;
    localparam logic [ADDR_W-1:0] OFS_STATIONARY_B_VOLTAGE = 12'h4d8;
    localparam logic [ADDR_W-1:0] OFS_DIRECT_AXIS_CURRENT = 12'h4e2;
    localparam logic [ADDR_W-1:0] OFS_QUADRATURE_CURRENT = 12'h4e4;
    localparam logic [ADDR_W-1:0] OFS_DIRECT_AXIS_VOLTAGE = 12'h4e6;
    localparam logic [ADDR_W-1:0] OFS_QUADRATURE_VOLTAGE = 12'h4e8;

    // monitor control and status
    localparam logic [ADDR_W-1:0] OFS_MONITOR_CONTROL = 12'h4f0;
    localparam logic [ADDR_W-1:0] OFS_MONITOR_STATUS = 12'h4f2;

    // word index inside the hold array
    localparam int IDX_STATIONARY_B_CURRENT = 0;
    localparam int IDX_STATIONARY_A_VOLTAGE = 1;
    localparam int IDX_STATIONARY_B_VOLTAGE = 2;
    localparam int IDX_DIRECT_AXIS_CURRENT = 3;
    localparam int IDX_QUADRATURE_CURRENT = 4;
    localparam int IDX_DIRECT_AXIS_VOLTAGE = 5;
    localparam int IDX_QUADRATURE_VOLTAGE = 6;

    // fixed point: value = word / 2^27 * scale
    localparam int FRAC_BITS = 27;

    // control fields
    localparam int CTRL_FREEZE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;

    // status fields
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_COUNT_W = 16;
    localparam int STAT_FROZEN_BIT = 16;
    localparam int STAT_DROP_BIT = 17;
    localparam int STAT_ROWRITE_BIT = 18;

    // reset values
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0;
    localparam logic [STAT_COUNT_W-1:0] COUNT_RESET = 16'h0;
    localparam logic FREEZE_RESET = 1'b0;

    // target of a register access
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_WORD = 2'b01,
        SEL_STAT = 2'b11,
        SEL_CTRL = 2'b10
    } fvm_sel_t;

endpackage : fvm_pkg

// File: hw/fvm_word_hold.sv
// fvm_word_hold: one observation word held in flip-flops
// assumes load and clear come from logic on the same clock
`timescale 1ns/1ps
module fvm_word_hold
    import fvm_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic load,
    input wire logic clear,
    // data
    input wire logic [WIDTH-1:0] sample,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] next_value;

    // software clear beats a sample landing in the same cycle
    always_comb begin
        next_value = value;
        if (clear) begin
            next_value = RESET_VALUE;
        end else if (load) begin
            next_value = sample;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end

endmodule : fvm_word_hold

// File: hw/fvm_vector_monitor.sv
// fvm_vector_monitor: read-only observation words of the vector control loop
// assumes the control computation runs on clk and pulses sampleValid per result
//
// Contract
// - beta current word, read-only, resets zero
// - alpha voltage word at 0x4d6, resets zero
// - beta voltage word at 0x4d8, resets zero
// - direct current word at 0x4e2, resets zero
// - quadrature current word at 0x4e4, resets zero
// - direct voltage word at 0x4e6, resets zero
// - quadrature voltage word at 0x4e8, resets zero
// - quadrature voltage coded as word/2^27*60/sqrt3
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module fvm_vector_monitor
    import fvm_pkg::*;
#(
    parameter int COUNT_W = STAT_COUNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regReadData,
    // control computation results, all fixed point with 27 fraction bits
    input wire logic sampleValid,
    input wire logic [DATA_W-1:0] stationaryBCurrent,
    input wire logic [DATA_W-1:0] stationaryAVoltage,
    input wire logic [DATA_W-1:0] stationaryBVoltage,
    input wire logic [DATA_W-1:0] directAxisCurrent,
    input wire logic [DATA_W-1:0] quadratureCurrent,
    input wire logic [DATA_W-1:0] directAxisVoltage,
    input wire logic [DATA_W-1:0] quadratureVoltage,
    // monitor state
    output logic monitorFrozen
);

    // decode used by both the read and the write path
    function automatic fvm_sel_t decode_target(input logic [ADDR_W-1:0] addr);
        fvm_sel_t sel;
        sel = SEL_NONE;
        if (addr == OFS_STATIONARY_B_CURRENT) begin
            sel = SEL_WORD;
        end else if (addr == OFS_STATIONARY_A_VOLTAGE) begin
            sel = SEL_WORD;
        end else if (addr == OFS_STATIONARY_B_VOLTAGE) begin
            sel = SEL_WORD;
        end else if (addr == OFS_DIRECT_AXIS_CURRENT) begin
            sel = SEL_WORD;
        end else if (addr == OFS_QUADRATURE_CURRENT) begin
            sel = SEL_WORD;
        end else if (addr == OFS_DIRECT_AXIS_VOLTAGE) begin
            sel = SEL_WORD;
        end else if (addr == OFS_QUADRATURE_VOLTAGE) begin
            sel = SEL_WORD;
        end else if (addr == OFS_MONITOR_CONTROL) begin
            sel = SEL_CTRL;
        end else if (addr == OFS_MONITOR_STATUS) begin
            sel = SEL_STAT;
        end
        return sel;
    endfunction : decode_target

    // hold array index for a word offset; only meaningful when SEL_WORD
    function automatic logic [2:0] word_index(input logic [ADDR_W-1:0] addr);
        logic [2:0] idx;
        idx = 3'h0;
        if (addr == OFS_STATIONARY_B_CURRENT) begin
            idx = 3'(IDX_STATIONARY_B_CURRENT);
        end else if (addr == OFS_STATIONARY_A_VOLTAGE) begin
            idx = 3'(IDX_STATIONARY_A_VOLTAGE);
        end else if (addr == OFS_STATIONARY_B_VOLTAGE) begin
            idx = 3'(IDX_STATIONARY_B_VOLTAGE);
        end else if (addr == OFS_DIRECT_AXIS_CURRENT) begin
            idx = 3'(IDX_DIRECT_AXIS_CURRENT);
        end else if (addr == OFS_QUADRATURE_CURRENT) begin
            idx = 3'(IDX_QUADRATURE_CURRENT);
        end else if (addr == OFS_DIRECT_AXIS_VOLTAGE) begin
            idx = 3'(IDX_DIRECT_AXIS_VOLTAGE);
        end else if (addr == OFS_QUADRATURE_VOLTAGE) begin
            idx = 3'(IDX_QUADRATURE_VOLTAGE);
        end
        return idx;
    endfunction : word_index

    // results gathered into an indexed array
    logic [DATA_W-1:0] sampleWord [NUM_WORDS];
    logic [DATA_W-1:0] heldWord [NUM_WORDS];

    assign sampleWord[IDX_STATIONARY_B_CURRENT] = stationaryBCurrent;
    assign sampleWord[IDX_STATIONARY_A_VOLTAGE] = stationaryAVoltage;
    assign sampleWord[IDX_STATIONARY_B_VOLTAGE] = stationaryBVoltage;
    assign sampleWord[IDX_DIRECT_AXIS_CURRENT] = directAxisCurrent;
    assign sampleWord[IDX_QUADRATURE_CURRENT] = quadratureCurrent;
    assign sampleWord[IDX_DIRECT_AXIS_VOLTAGE] = directAxisVoltage;
    // word passed through untouched; scaling lives in the computation
    assign sampleWord[IDX_QUADRATURE_VOLTAGE] = quadratureVoltage;

    // access decode
    fvm_sel_t writeSel;
    fvm_sel_t readSel;
    logic [2:0] readIdx;

    assign writeSel = regWrite ? decode_target(regAddr) : SEL_NONE;
    assign readSel = regRead ? decode_target(regAddr) : SEL_NONE;
    assign readIdx = word_index(regAddr);

    // control and status state
    logic freeze;
    logic next_freeze;
    logic dropped;
    logic next_dropped;
    logic roWrite;
    logic next_roWrite;
    logic [COUNT_W-1:0] updateCount;
    logic [COUNT_W-1:0] next_updateCount;
    logic clearPulse;
    logic acceptSample;
    logic dropSet;
    logic roWriteSet;

    // freeze holds all seven words together so software sees one coherent set
    assign acceptSample = sampleValid && !freeze;
    assign dropSet = sampleValid && freeze;
    // a write to an observation word changes nothing but this flag
    assign roWriteSet = (writeSel == SEL_WORD);
    assign clearPulse = (writeSel == SEL_CTRL) && regWriteData[CTRL_CLEAR_BIT];

    always_comb begin
        next_freeze = freeze;
        next_dropped = dropped;
        next_roWrite = roWrite;
        next_updateCount = updateCount;
        if (writeSel == SEL_CTRL) begin
            next_freeze = regWriteData[CTRL_FREEZE_BIT];
        end
        // status flags clear on writing one; a new event the same cycle wins
        if (writeSel == SEL_STAT && regWriteData[STAT_DROP_BIT]) begin
            next_dropped = 1'b0;
        end
        if (dropSet) begin
            next_dropped = 1'b1;
        end
        if (writeSel == SEL_STAT && regWriteData[STAT_ROWRITE_BIT]) begin
            next_roWrite = 1'b0;
        end
        if (roWriteSet) begin
            next_roWrite = 1'b1;
        end
        if (clearPulse) begin
            next_updateCount = COUNT_RESET[COUNT_W-1:0];
        end else if (acceptSample) begin
            // wraps silently; software compares deltas
            next_updateCount = updateCount + COUNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            freeze <= FREEZE_RESET;
            dropped <= 1'b0;
            roWrite <= 1'b0;
            updateCount <= COUNT_RESET[COUNT_W-1:0];
        end else begin
            freeze <= next_freeze;
            dropped <= next_dropped;
            roWrite <= next_roWrite;
            updateCount <= next_updateCount;
        end
    end

    assign monitorFrozen = freeze;

    // observation words
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WORDS; gi++) begin : g_hold
            fvm_word_hold #(
                .WIDTH(DATA_W),
                .RESET_VALUE(WORD_RESET)
            ) u_hold (
                .clk(clk),
                .reset(reset),
                .load(acceptSample),
                .clear(clearPulse),
                .sample(sampleWord[gi]),
                .value(heldWord[gi])
            );
        end
    endgenerate

    // status word assembly
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] controlWord;

    always_comb begin
        statusWord = '0;
        statusWord[STAT_COUNT_LSB +: COUNT_W] = updateCount;
        statusWord[STAT_FROZEN_BIT] = freeze;
        statusWord[STAT_DROP_BIT] = dropped;
        statusWord[STAT_ROWRITE_BIT] = roWrite;
        controlWord = '0;
        // clear is a pulse and always reads back zero
        controlWord[CTRL_FREEZE_BIT] = freeze;
    end

    // read path: data stands in the cycle after the strobe, zero otherwise
    logic [DATA_W-1:0] next_regReadData;

    always_comb begin
        next_regReadData = RDATA_RESET;
        case (readSel)
            SEL_WORD: begin
                // a sample in the same cycle shows on the next read
                next_regReadData = heldWord[readIdx];
            end
            SEL_CTRL: begin
                next_regReadData = controlWord;
            end
            SEL_STAT: begin
                next_regReadData = statusWord;
            end
            default: begin
                next_regReadData = RDATA_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regReadData <= RDATA_RESET;
        end else begin
            regReadData <= next_regReadData;
        end
    end

endmodule : fvm_vector_monitor

// File: verification/fvm_vector_monitor_assertions.sv
// fvm_vector_monitor_assertions: port-level checks of the vector monitor
// assumes one clock domain; bound onto every fvm_vector_monitor instance
`timescale 1ns/1ps
module fvm_vector_monitor_assertions
    import fvm_pkg::*;
#(
    parameter int COUNT_W = STAT_COUNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regReadData,
    // results
    input wire logic sampleValid,
    input wire logic [DATA_W-1:0] stationaryBCurrent,
    input wire logic [DATA_W-1:0] stationaryAVoltage,
    input wire logic [DATA_W-1:0] stationaryBVoltage,
    input wire logic [DATA_W-1:0] directAxisCurrent,
    input wire logic [DATA_W-1:0] quadratureCurrent,
    input wire logic [DATA_W-1:0] directAxisVoltage,
    input wire logic [DATA_W-1:0] quadratureVoltage,
    // state
    input wire logic monitorFrozen
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    property p_idle_zero;
        !regRead |=> regReadData == '0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
    // write excluded: a same-cycle clear would change the outcome; a freeze only acts a cycle later
    property p_qv_read;
        sampleValid && !monitorFrozen && !regWrite ##1 regRead && regAddr == OFS_QUADRATURE_VOLTAGE
            |=> regReadData == $past(quadratureVoltage, 2);
    endproperty
    a_qv_read: assert property (p_qv_read) else $error("quadrature voltage not latest");
    property p_dac_read;
        sampleValid && !monitorFrozen && !regWrite ##1 regRead && regAddr == OFS_DIRECT_AXIS_CURRENT
            |=> regReadData == $past(directAxisCurrent, 2);
    endproperty
    a_dac_read: assert property (p_dac_read) else $error("direct current not latest");
    property p_va_read;
        sampleValid && !monitorFrozen && !regWrite ##1 regRead && regAddr == OFS_STATIONARY_A_VOLTAGE
            |=> regReadData == $past(stationaryAVoltage, 2);
    endproperty
    a_va_read: assert property (p_va_read) else $error("alpha voltage not latest");
    property p_freeze_set;
        regWrite && regAddr == OFS_MONITOR_CONTROL
            |=> monitorFrozen == $past(regWriteData[CTRL_FREEZE_BIT]);
    endproperty
    a_freeze_set: assert property (p_freeze_set) else $error("freeze not taken");
    property p_freeze_hold;
        !(regWrite && regAddr == OFS_MONITOR_CONTROL) |=> $stable(monitorFrozen);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("freeze moved unasked");
    property p_unmapped;
        regRead && regAddr == 12'h4da |=> regReadData == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat_frozen;
        regRead && regAddr == OFS_MONITOR_STATUS
            |=> regReadData[STAT_FROZEN_BIT] == $past(monitorFrozen) && regReadData[31:19] == '0;
    endproperty
    a_stat_frozen: assert property (p_stat_frozen) else $error("status frozen bit wrong");
    property p_clear;
        regWrite && regAddr == OFS_MONITOR_CONTROL && regWriteData[CTRL_CLEAR_BIT]
            ##1 regRead && regAddr == OFS_QUADRATURE_CURRENT |=> regReadData == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left a word set");

    c_qv_read: cover property (p_qv_read);
    c_drop: cover property (sampleValid && monitorFrozen);
    c_ro_write: cover property (regWrite && regAddr == OFS_DIRECT_AXIS_VOLTAGE);
endmodule : fvm_vector_monitor_assertions

bind fvm_vector_monitor fvm_vector_monitor_assertions #(.COUNT_W(COUNT_W)) u_chk (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .sampleValid(sampleValid), .stationaryBCurrent(stationaryBCurrent),
    .stationaryAVoltage(stationaryAVoltage), .stationaryBVoltage(stationaryBVoltage),
    .directAxisCurrent(directAxisCurrent), .quadratureCurrent(quadratureCurrent),
    .directAxisVoltage(directAxisVoltage), .quadratureVoltage(quadratureVoltage),
    .monitorFrozen(monitorFrozen)
);

// File: verification/tb_top.sv
// tb_top: register-level bench of the vector monitor
// assumes the checker is bound in; bench drives results and register port
`timescale 1ns/1ps
module tb_top
    import fvm_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWriteData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic sampleValid = 1'b0;
    logic [DATA_W-1:0] regReadData;
    logic monitorFrozen;
    logic [DATA_W-1:0] sv [NUM_WORDS] = '{default: '0};
    logic [ADDR_W-1:0] ofs [NUM_WORDS] = '{OFS_STATIONARY_B_CURRENT, OFS_STATIONARY_A_VOLTAGE,
        OFS_STATIONARY_B_VOLTAGE, OFS_DIRECT_AXIS_CURRENT, OFS_QUADRATURE_CURRENT,
        OFS_DIRECT_AXIS_VOLTAGE, OFS_QUADRATURE_VOLTAGE};
    int mismatches = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;

    fvm_vector_monitor u_dut (
        .clk(clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .sampleValid(sampleValid), .stationaryBCurrent(sv[0]), .stationaryAVoltage(sv[1]),
        .stationaryBVoltage(sv[2]), .directAxisCurrent(sv[3]), .quadratureCurrent(sv[4]),
        .directAxisVoltage(sv[5]), .quadratureVoltage(sv[6]), .monitorFrozen(monitorFrozen)
    );

    // pattern 0 means every word cleared
    function automatic logic [31:0] pat(input logic [3:0] b, input int i);
        return (b == 4'h0) ? 32'h0 : {4'h8, b, 20'h5a5c3, 4'(i)};
    endfunction : pat

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // each strobe assigned once per step, so calls may follow back to back
    task automatic op(input logic r, input logic w, input logic s, input logic [11:0] a,
            input logic [31:0] d);
        regRead <= r;
        regWrite <= w;
        sampleValid <= s;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
    endtask : op

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        op(1'b0, 1'b1, 1'b0, a, d);
    endtask : wr

    // read data stands only in the cycle after the strobe edge
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        op(1'b1, 1'b0, 1'b0, a, 32'h0);
        #1;
        chk($sformatf("word %h", a), e, regReadData);
        op(1'b0, 1'b0, 1'b0, a, 32'h0);
    endtask : rc

    task automatic smp(input logic [3:0] b);
        for (int i = 0; i < NUM_WORDS; i++) begin
            sv[i] <= pat(b, i);
        end
        op(1'b0, 1'b0, 1'b1, 12'h0, 32'h0);
    endtask : smp

    task automatic chkw(input logic [3:0] b);
        for (int i = 0; i < NUM_WORDS; i++) begin
            rc(ofs[i], pat(b, i));
        end
    endtask : chkw

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        chkw(4'h0);
        rc(OFS_MONITOR_STATUS, 32'h0);
        rc(12'h4da, 32'h0);
        smp(4'h1);
        rc(OFS_QUADRATURE_VOLTAGE, pat(4'h1, 6));
        smp(4'h2);
        rc(OFS_DIRECT_AXIS_CURRENT, pat(4'h2, 3));
        smp(4'h3);
        rc(OFS_STATIONARY_A_VOLTAGE, pat(4'h3, 1));
        chkw(4'h3);
        for (int i = 0; i < NUM_WORDS; i++) begin
            wr(ofs[i], 32'hffff_ffff);
        end
        wr(12'h4da, 32'hffff_ffff);
        rc(12'h4da, 32'h0);
        chkw(4'h3);
        rc(OFS_MONITOR_STATUS, 32'h0004_0003);
        wr(OFS_MONITOR_CONTROL, 32'h1);
        rc(OFS_MONITOR_CONTROL, 32'h1);
        chk("frozen", 32'h1, {31'h0, monitorFrozen});
        smp(4'h4);
        chkw(4'h3);
        rc(OFS_MONITOR_STATUS, 32'h0007_0003);
        wr(OFS_MONITOR_CONTROL, 32'h0);
        wr(OFS_MONITOR_STATUS, 32'h0006_0000);
        rc(OFS_MONITOR_STATUS, 32'h0000_0003);
        smp(4'h5);
        chkw(4'h5);
        wr(OFS_MONITOR_CONTROL, 32'h2);
        rc(OFS_QUADRATURE_CURRENT, 32'h0);
        chkw(4'h0);
        rc(OFS_MONITOR_STATUS, 32'h0);
        close_out();
    end
endmodule : tb_top
